// ### gp_pkg.sv
// Shared constants and types for the sixteen-pin general purpose port
package gp_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int          NUM_PINS    = 16;
    localparam int          NUM_ANA     = 4;
    localparam int          ADC_BITS    = 12;
    // Bus writes reach only the lower fourteen pins
    localparam logic [15:0] BUS_WR_MASK = 16'h3fff;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] DIR_RST     = 16'h0000;
    localparam logic [15:0] OUT_RST     = 16'h0000;
    localparam logic [3:0]  ANA_RST     = 4'h0;

    // ------------------------------------------------------------
    // Master reset pin timing
    // ------------------------------------------------------------
    localparam int          CLK_NS      = 20;
    localparam int          RST_MIN_NS  = 2000;
    // Longest low time that may be ignored, in whole cycles
    localparam int          RST_LOW_CYC = RST_MIN_NS / CLK_NS;
    localparam int          RST_CNT_W   = 8;

    // ------------------------------------------------------------
    // Per-pin modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {GP_IN, GP_OUT, GP_ANA} gp_mode_t;

endpackage : gp_pkg

// ### gp_rst_if.sv
// Carrier between the master reset filter and the port core
`timescale 1ns/10ps
interface gp_rst_if;
    logic pin_n;   // Master reset pin level, low asks for reset
    logic req;     // Filtered device reset request, level

    modport filt (input pin_n, output req);
    modport core (output pin_n, input req);
endinterface : gp_rst_if

// ### gp_rst_filter.sv
// Glitch filter on the master reset pin, input only
`timescale 1ns/10ps
module gp_rst_filter
#(
    parameter int LOW_CYC = gp_pkg::RST_LOW_CYC
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Link to the port core
    gp_rst_if.filt    rst
);
    import gp_pkg::*;

    // Counter must hold one more than the ignored low time
    if (LOW_CYC < 1 || LOW_CYC + 1 >= (1 << RST_CNT_W))
    begin : g_chk
        $error("gp_rst_filter: LOW_CYC out of range");
    end

    typedef struct packed {
        logic [RST_CNT_W-1:0] cnt;
        logic                 req;
    } gp_filt_t;

    gp_filt_t st_r;
    gp_filt_t st_nxt;

    localparam logic [RST_CNT_W-1:0] LIM = RST_CNT_W'(LOW_CYC);

    // ------------------------------------------------------------
    // Low-time counter
    // ------------------------------------------------------------
    // reset after long low
    always_comb
    begin
        st_nxt = st_r;
        if (rst.pin_n)
        begin
            st_nxt.cnt = '0;
            st_nxt.req = 1'b0;
        end
        else if (st_r.cnt == LIM)
        begin
            st_nxt.req = 1'b1;   // Low for more than the minimum
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign rst.req = st_r.req;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_held_full;
        !rst.pin_n && st_r.cnt == LIM;
    endsequence

    sequence s_held_short;
        !rst.pin_n && st_r.cnt < LIM && !st_r.req;
    endsequence

    a_long_pulse_reset: assert property (@(posedge clk) disable iff (!reset_n)
        s_held_full |=> rst.req)
        else $error("Long reset pulse did not reset");

    a_short_pulse_ignored: assert property (@(posedge clk) disable iff (!reset_n)
        s_held_short |=> !rst.req)
        else $error("Short reset pulse caused a reset");

endmodule : gp_rst_filter

// ### gp_port.sv
// Sixteen-pin general purpose port with per-pin direction and analog mode on the lower four pins
`timescale 1ns/10ps
module gp_port
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // Master reset pin, sampled only
    input  wire logic                     master_rst_n,
    // Pins
    input  wire logic [15:0]              pin_in,
    output logic      [15:0]              pin_out_r,
    output logic      [15:0]              pin_oe_r,
    // Per-pin mode command
    input  wire logic                     dir_wr,
    input  wire logic [3:0]               dir_sel,
    input  wire gp_pkg::gp_mode_t         dir_mode,
    // Single-pin access
    input  wire logic                     pin_wr,
    input  wire logic [3:0]               pin_sel,
    input  wire logic                     pin_val,
    input  wire logic                     pin_rd,
    // Parallel bus access
    input  wire logic                     bus_wr,
    input  wire logic [15:0]              bus_wdata,
    input  wire logic                     bus_rd,
    output logic      [15:0]              rd_data_r,
    output logic                          rd_valid_r,
    // Analog converter results
    input  wire logic                     adc_valid,
    input  wire logic [1:0]               adc_chan,
    input  wire logic [11:0]              adc_data,
    output logic      [3:0]               ana_en_r,
    output logic      [47:0]              ana_res_r,
    output logic      [3:0]               ana_new_r,
    // Device reset in progress
    output logic                          dev_rst_r
);
    import gp_pkg::*;

    typedef struct packed {
        logic [15:0] oe;
        logic [15:0] out;
        logic [3:0]  ana;
        logic [15:0] rdata;
        logic        rvalid;
        logic [47:0] ares;
        logic [3:0]  anew;
        logic        drst;
    } gp_state_t;

    gp_state_t st_r;
    gp_state_t st_nxt;
    logic      rst_all;
    logic [15:0] pin_view;

    // ------------------------------------------------------------
    // Master reset filter
    // ------------------------------------------------------------
    gp_rst_if rst_if ();

    assign rst_if.pin_n = master_rst_n;

    gp_rst_filter u_filt
    (
        .clk     (clk),
        .reset_n (reset_n),
        .rst     (rst_if)
    );

    // Either the system reset or a long pin pulse clears the port
    assign rst_all = !reset_n || rst_if.req;

    // Inputs show the pin, outputs read back the latch, analog pins read zero
    // Built per bit so the analog flag is only indexed where it exists
    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_view
        if (i < NUM_ANA)
        begin : g_ana
            assign pin_view[i] = st_r.ana[i] ? 1'b0
                               : (st_r.oe[i] ? st_r.out[i] : pin_in[i]);
        end
        else
        begin : g_dig
            assign pin_view[i] = st_r.oe[i] ? st_r.out[i] : pin_in[i];
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.rvalid = 1'b0;
        st_nxt.anew   = 4'h0;
        st_nxt.drst   = rst_if.req;
        if (dir_wr)
        begin
            case (dir_mode)
                GP_OUT:
                begin
                    st_nxt.oe[dir_sel] = 1'b1;
                    if (dir_sel < 4'(NUM_ANA))
                        st_nxt.ana[dir_sel[1:0]] = 1'b0;
                end
                GP_ANA:
                begin
                    // analog only on the lowest pins
                    if (dir_sel < 4'(NUM_ANA))
                    begin
                        st_nxt.oe[dir_sel]       = 1'b0;
                        st_nxt.ana[dir_sel[1:0]] = 1'b1;
                    end
                end
                default:
                begin
                    st_nxt.oe[dir_sel] = 1'b0;
                    if (dir_sel < 4'(NUM_ANA))
                        st_nxt.ana[dir_sel[1:0]] = 1'b0;
                end
            endcase
        end
        if (bus_wr)
        begin
            st_nxt.out = (bus_wdata & BUS_WR_MASK) | (st_r.out & ~BUS_WR_MASK);
        end
        // Single-pin write applied last, so it wins over a bus write
        if (pin_wr)
            st_nxt.out[pin_sel] = pin_val;
        if (bus_rd)
        begin
            st_nxt.rdata  = pin_view;
            st_nxt.rvalid = 1'b1;
        end
        else if (pin_rd)
        begin
            st_nxt.rdata  = {15'h0000, pin_view[pin_sel]};
            st_nxt.rvalid = 1'b1;
        end
        // 12-bit result kept per analog pin
        if (adc_valid && st_r.ana[adc_chan])
        begin
            st_nxt.ares[adc_chan*ADC_BITS +: ADC_BITS] = adc_data;
            st_nxt.anew[adc_chan]                      = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // all inputs after reset
    always_ff @(posedge clk)
    begin
        if (rst_all)
        begin
            st_r      <= '0;
            st_r.oe   <= DIR_RST;
            st_r.out  <= OUT_RST;
            st_r.ana  <= ANA_RST;
            st_r.drst <= rst_if.req;   // Still flag a pin reset while it acts
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    assign pin_out_r  = st_r.out;
    assign pin_oe_r   = st_r.oe;
    assign rd_data_r  = st_r.rdata;
    assign rd_valid_r = st_r.rvalid;
    assign ana_en_r   = st_r.ana;
    assign ana_res_r  = st_r.ares;
    assign ana_new_r  = st_r.anew;
    assign dev_rst_r  = st_r.drst;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_set_out;
        dir_wr && dir_mode == GP_OUT && !rst_if.req;
    endsequence

    a_dir_set_out: assert property (@(posedge clk) disable iff (!reset_n)
        s_set_out |=> pin_oe_r[$past(dir_sel)])
        else $error("Pin not driven after output setting");

    a_bus_read_word: assert property (@(posedge clk) disable iff (!reset_n)
        bus_rd && !rst_if.req && ana_en_r == 4'h0
        |=> rd_valid_r && rd_data_r == $past((pin_in & ~pin_oe_r) | (pin_out_r & pin_oe_r)))
        else $error("Bus read word wrong");

    a_analog_mode_set: assert property (@(posedge clk) disable iff (!reset_n)
        dir_wr && dir_mode == GP_ANA && dir_sel < 4'h4 && !rst_if.req
        |=> ana_en_r[$past(dir_sel[1:0])] && !pin_oe_r[$past(dir_sel)])
        else $error("Analog mode not taken");

    a_reset_all_inputs: assert property (@(posedge clk) disable iff (!reset_n)
        rst_if.req |=> pin_oe_r == 16'h0000 && ana_en_r == 4'h0)
        else $error("Pins not inputs after reset");

    a_adc_result_kept: assert property (@(posedge clk) disable iff (!reset_n)
        adc_valid && ana_en_r[adc_chan] && !rst_if.req
        |=> ana_new_r[$past(adc_chan)]
            && ana_res_r[$past(adc_chan)*12 +: 12] == $past(adc_data))
        else $error("Analog result not stored");

    a_top_pins_kept: assert property (@(posedge clk) disable iff (!reset_n)
        bus_wr && !pin_wr && !rst_if.req
        |=> pin_out_r[15:14] == $past(pin_out_r[15:14]))
        else $error("Bus write touched top pins");

endmodule : gp_port

// ### gp_pins_model.sv
// External circuitry model standing on the general purpose pins
`timescale 1ns/10ps
module gp_pins_model
(
    // Port side
    input  wire logic [15:0] pin_out_r,
    input  wire logic [15:0] pin_oe_r,
    output logic      [15:0] pin_in,
    output logic             master_rst_n,
    // Scenario control
    input  wire logic [15:0] ext_val,
    input  wire logic        pull_low
);
    // Driven pins show the latch, released pins show the outside level
    assign pin_in = (pin_oe_r & pin_out_r) | (~pin_oe_r & ext_val);
    // open collector reset
    // Drives a plain high when released, standing in for the resistor to supply that gives the idle high
    assign master_rst_n = pull_low ? 1'b0 : 1'b1;
endmodule : gp_pins_model

// ### gp_port_tb_top.sv
// Self-checking testbench for the sixteen-pin general purpose port
`timescale 1ns/10ps
module gp_port_tb_top;
    import gp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, reset_n, master_rst_n, pull_low;
    logic [15:0] pin_in, pin_out_r, pin_oe_r, ext_val, bus_wdata, rd_data_r;
    logic dir_wr, pin_wr, pin_val, pin_rd, bus_wr, bus_rd, rd_valid_r;
    logic adc_valid, dev_rst_r;
    logic [3:0] dir_sel, pin_sel, ana_en_r, ana_new_r;
    logic [1:0] adc_chan;
    logic [11:0] adc_data;
    logic [47:0] ana_res_r;
    gp_mode_t dir_mode;
    int errors, tests_run;
    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    gp_port uut (.clk(clk), .reset_n(reset_n), .master_rst_n(master_rst_n),
        .pin_in(pin_in), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
        .dir_wr(dir_wr), .dir_sel(dir_sel), .dir_mode(dir_mode), .pin_wr(pin_wr),
        .pin_sel(pin_sel), .pin_val(pin_val), .pin_rd(pin_rd), .bus_wr(bus_wr),
        .bus_wdata(bus_wdata), .bus_rd(bus_rd), .rd_data_r(rd_data_r),
        .rd_valid_r(rd_valid_r), .adc_valid(adc_valid), .adc_chan(adc_chan),
        .adc_data(adc_data), .ana_en_r(ana_en_r), .ana_res_r(ana_res_r),
        .ana_new_r(ana_new_r), .dev_rst_r(dev_rst_r));
    gp_pins_model pins (.pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r), .pin_in(pin_in),
        .master_rst_n(master_rst_n), .ext_val(ext_val), .pull_low(pull_low));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Inputs always change 1 ns after the edge, so sampling never races
    task automatic step;
        @(posedge clk);
        #1;
    endtask : step
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Each command first lets an edge pass, so a strobe is never raised
    // again in the same time step that lowered it
    task automatic set_mode(input logic [3:0] sel, input gp_mode_t mode);
        step();
        dir_wr = 1'b1;
        dir_sel = sel;
        dir_mode = mode;
        step();
        dir_wr = 1'b0;
    endtask : set_mode
    task automatic wr_pin(input logic [3:0] sel, input logic val);
        step();
        pin_wr = 1'b1;
        pin_sel = sel;
        pin_val = val;
        step();
        pin_wr = 1'b0;
    endtask : wr_pin
    task automatic wr_bus(input logic [15:0] data);
        step();
        bus_wr = 1'b1;
        bus_wdata = data;
        step();
        bus_wr = 1'b0;
    endtask : wr_bus
    // Read data is judged in the one cycle that the valid pulse stands;
    // a single-pin read must also show zero above bit 0
    task automatic rd(input logic whole, input logic [3:0] sel, input logic [15:0] exp);
        step();
        bus_rd = whole;
        pin_rd = !whole;
        pin_sel = sel;
        step();
        bus_rd = 1'b0;
        pin_rd = 1'b0;
        check(rd_valid_r, 1'b1);
        check(rd_data_r, exp);
    endtask : rd
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check({pin_oe_r, pin_out_r, ana_en_r, dev_rst_r}, 37'h0);
        rd(1'b1, 4'h0, ext_val);
    endtask : t_reset
    task automatic t_single;
        set_mode(4'h5, GP_OUT);
        wr_pin(4'h5, 1'b1);
        check({pin_oe_r, pin_out_r}, {16'h0020, 16'h0020});
        rd(1'b0, 4'h5, 16'h0001);
        rd(1'b0, 4'h6, {15'h0, ext_val[6]});
    endtask : t_single
    task automatic t_bus;
        for (int i = 0; i < NUM_PINS; i++) set_mode(4'(i), GP_OUT);
        check(pin_oe_r, 16'hffff);
        wr_bus(16'hffff);
        check(pin_out_r, 16'h3fff);
        rd(1'b1, 4'h0, 16'h3fff);
        wr_pin(4'hf, 1'b1);
        wr_bus(16'h0000);
        check(pin_out_r, 16'h8000);
    endtask : t_bus
    task automatic t_analog;
        set_mode(4'h0, GP_ANA);
        set_mode(4'h4, GP_ANA);
        check({pin_oe_r[4], pin_oe_r[0], ana_en_r}, 6'h21);
        adc_valid = 1'b1; adc_chan = 2'h0; adc_data = 12'habc;
        step();
        check({ana_new_r, ana_res_r[11:0]}, {4'h1, 12'habc});
        adc_chan = 2'h1;
        step();
        adc_valid = 1'b0;
        check({ana_new_r, ana_res_r[23:12]}, 16'h0);
        rd(1'b0, 4'h0, 16'h0);
        set_mode(4'h4, GP_IN);
        check({pin_oe_r[4], ana_en_r}, 5'h01);
    endtask : t_analog
    // Exactly 100 low edges (2 us) are ignored; the 101st asks for a reset
    task automatic t_mreset;
        pull_low = 1'b1;
        repeat (100) step();
        pull_low = 1'b0;
        step();
        check({dev_rst_r, ana_en_r}, 5'h01);
        pull_low = 1'b1;
        repeat (101) step();
        pull_low = 1'b0;
        step();
        check({dev_rst_r, pin_oe_r, pin_out_r, ana_en_r}, {1'b1, 36'h0});
        repeat (3) step();
        set_mode(4'h2, GP_OUT);
        check({dev_rst_r, pin_oe_r}, 17'h0004);
    endtask : t_mreset
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    // Free-running clock, 20 ns period
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Watchdog, far above the few hundred cycles the run needs
    initial
    begin
        #200us;
        errors++;
        finish_test();
    end
    initial
    begin
        errors = 0; tests_run = 0; reset_n = 1'b0; pull_low = 1'b0;
        ext_val = 16'ha5c3; dir_wr = 1'b0; dir_sel = 4'h0; dir_mode = GP_IN;
        pin_wr = 1'b0; pin_sel = 4'h0; pin_val = 1'b0; pin_rd = 1'b0;
        bus_wr = 1'b0; bus_wdata = 16'h0; bus_rd = 1'b0;
        adc_valid = 1'b0; adc_chan = 2'h0; adc_data = 12'h0;
        repeat (8) step();
        reset_n = 1'b1;
        t_reset();
        t_single();
        t_bus();
        t_analog();
        t_mreset();
        finish_test();
    end
endmodule : gp_port_tb_top
